// *** src/apwm_dac.sv ***
// ============================================================
// Audio PWM D/A top: control register, sample buffer, modulator.
// Assumes processor writes are one-cycle strobes synchronous to mclk_in.
`timescale 1ns/1ns
module apwm_dac #(
  parameter int SAMPLE_W = apwm_pkg::APWM_SAMPLE_W,
  parameter int CNT_W    = apwm_pkg::APWM_CNT_W
) (
  // Clock and reset.
  input  wire logic                mclk_in,
  input  wire logic                arst_n_in,
  // Control register port.
  input  wire logic                ctrl_wr_in,
  input  wire logic [7:0]          ctrl_wdata_in,
  output logic      [7:0]          ctrl_rdata_out,
  // Sample buffer port.
  input  wire logic                sample_wr_in,
  input  wire logic [SAMPLE_W-1:0] sample_wdata_in,
  // Pads and interrupt tick.
  output logic                     audio_out_a_out,
  output logic                     audio_out_b_out,
  output logic                     sample_interrupt_tick_out
);

  // ============================================================
  // State record.
  typedef struct packed {
    logic [7:0]           ctrl;
    logic [SAMPLE_W-1:0]  sbuf;
    apwm_pkg::apwm_phase_e phase;
    logic [CNT_W-1:0]     period;
    logic [CNT_W-1:0]     cnt;
    logic                 ovf;
    logic                 sign;
    logic [2:0]           latches;
    apwm_pkg::apwm_pads_s pads;
  } apwm_state_s;

  apwm_state_s st;
  apwm_state_s next_st;
  logic        base_tick;

  // Magnitude of a sample for the chosen counter width.
  function automatic logic [CNT_W-1:0] apwm_mag(input logic [SAMPLE_W-1:0] s,
                                                input logic w7);
    if (w7) begin
      apwm_mag = s[CNT_W-1:0];
    end else begin
      apwm_mag = {1'b0, s[CNT_W-1:1]};
    end
  endfunction

  // Number of sample latches per interrupt, minus one.
  function automatic logic [2:0] apwm_ratio_m1(input logic [1:0] code);
    apwm_ratio_m1 = 3'((4'h1 << code) - 4'h1);
  endfunction

  // ============================================================
  // Base clock from the preload prescaler.
  // prescale from bits 3..5
  apwm_prescaler #(
    .PRE_W(apwm_pkg::APWM_PRE_W)
  ) u_pre (
    .mclk_in       (mclk_in),
    .arst_n_in     (arst_n_in),
    .preload_in    (st.ctrl[apwm_pkg::APWM_PRE_LSB +: apwm_pkg::APWM_PRE_W]),
    .base_tick_out (base_tick)
  );

  // ============================================================
  // Next-state logic for registers, sequencer and pad latch.
  always_comb begin
    logic             dis;
    logic             w7;
    logic [CNT_W-1:0] last;
    logic             pwm;
    dis  = 1'b0;
    w7   = 1'b0;
    last = '0;
    pwm  = 1'b0;
    next_st = st;
    next_st.pads.tick = 1'b0;
    if (ctrl_wr_in) begin
      next_st.ctrl = ctrl_wdata_in;
    end
    if (sample_wr_in) begin
      next_st.sbuf = sample_wdata_in;
    end
    dis  = st.ctrl[apwm_pkg::APWM_DIS_BIT];
    w7   = st.ctrl[apwm_pkg::APWM_W7_BIT];
    // period 64 or 128 base ticks
    last = w7 ? {CNT_W{1'b1}} : {1'b0, {(CNT_W-1){1'b1}}};
    case (st.phase)
      apwm_pkg::APWM_IDLE: begin
        if (!dis) begin
          next_st.phase = apwm_pkg::APWM_ARM;
        end
      end
      apwm_pkg::APWM_ARM: begin
        if (dis) begin
          next_st.phase = apwm_pkg::APWM_IDLE;
        end else if (base_tick) begin
          next_st.phase  = apwm_pkg::APWM_RUN;
          next_st.period = '0;
          next_st.cnt     = apwm_mag(st.sbuf, w7);
          next_st.sign    = st.sbuf[SAMPLE_W-1];
          next_st.ovf     = 1'b0;
          next_st.latches = '0;
        end
      end
      apwm_pkg::APWM_RUN: begin
        if (dis) begin
          next_st.phase = apwm_pkg::APWM_IDLE;
        end else if (base_tick) begin
          if (st.period == last) begin
            next_st.period = '0;
            next_st.cnt    = apwm_mag(st.sbuf, w7);
            next_st.sign   = st.sbuf[SAMPLE_W-1];
            next_st.ovf    = 1'b0;
            if (st.latches >= apwm_ratio_m1(
                  st.ctrl[apwm_pkg::APWM_RATIO_LSB +: apwm_pkg::APWM_RATIO_W])) begin
              next_st.latches   = '0;
              next_st.pads.tick = 1'b1;
            end else begin
              next_st.latches = st.latches + 3'h1;
            end
          end else begin
            next_st.period = st.period + 1'b1;
            next_st.cnt    = (st.cnt == last) ? '0 : st.cnt + 1'b1;
            if (st.cnt == last) begin
              next_st.ovf = 1'b1;
            end
          end
        end
      end
      default: begin
        next_st.phase = apwm_pkg::APWM_IDLE;
      end
    endcase
    // Output latch; the pad follows the overflow flag one cycle later.
    pwm = (st.phase == apwm_pkg::APWM_RUN) && st.ovf;
    if (dis || st.phase != apwm_pkg::APWM_RUN) begin
      next_st.pads.out_a = 1'b0;
      next_st.pads.out_b = 1'b0;
    end else if (st.ctrl[apwm_pkg::APWM_BUZ_BIT]) begin
      next_st.pads.out_a = pwm ^ st.sign;
      next_st.pads.out_b = ~(pwm ^ st.sign);
    end else begin
      // speaker: sign picks the pulsing pad
      next_st.pads.out_a = pwm & ~st.sign;
      next_st.pads.out_b = pwm & st.sign;
    end
  end

  // ============================================================
  // State register. The control word has no defined reset value,
  // so the output starts disabled to keep the pads quiet.
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st       <= '0;
      st.ctrl  <= apwm_pkg::APWM_CTRL_RST;
      st.sbuf  <= apwm_pkg::APWM_SAMPLE_RST;
      st.phase <= apwm_pkg::APWM_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops.
  assign ctrl_rdata_out            = st.ctrl;
  assign audio_out_a_out           = st.pads.out_a;
  assign audio_out_b_out           = st.pads.out_b;
  assign sample_interrupt_tick_out = st.pads.tick;

endmodule

// *** src/apwm_pkg.sv ***
// ============================================================
// Audio PWM D/A package: control layout, reset values, timing.
// Assumes one 250 MHz system clock and an 8-bit control word.
package apwm_pkg;

  // ============================================================
  // Register map and control field positions.
  localparam logic [7:0] APWM_CTRL_ADDR    = 8'h27;
  localparam int         APWM_DIS_BIT      = 0;
  localparam int         APWM_BUZ_BIT      = 1;
  localparam int         APWM_W7_BIT       = 2;
  localparam int         APWM_PRE_LSB      = 3;
  localparam int         APWM_PRE_W        = 3;
  localparam int         APWM_RATIO_LSB    = 6;
  localparam int         APWM_RATIO_W      = 2;
  localparam logic [7:0] APWM_CTRL_RST     = 8'h01;
  localparam logic [7:0] APWM_SAMPLE_RST   = 8'h00;
  localparam int         APWM_SAMPLE_W     = 8;
  localparam int         APWM_CNT_W        = 7;

  // ============================================================
  // Timing: nominal modulation rate and clock figures.
  localparam int         APWM_CLK_MHZ      = 250;
  localparam int         APWM_BASE_RATE_HZ = 32000;

  // ============================================================
  // Types.
  typedef enum logic [1:0] {APWM_IDLE, APWM_ARM, APWM_RUN} apwm_phase_e;

  typedef struct packed {
    logic       out_a;
    logic       out_b;
    logic       tick;
  } apwm_pads_s;

endpackage

// *** src/apwm_prescaler.sv ***
// ============================================================
// Preload prescaler: one-cycle base clock enable every n+1 cycles.
// Assumes the preload value is stable or changes between periods.
`timescale 1ns/1ns
module apwm_prescaler #(
  parameter int PRE_W = 3
) (
  // Clock and reset.
  input  wire logic             mclk_in,
  input  wire logic             arst_n_in,
  // Control.
  input  wire logic [PRE_W-1:0] preload_in,
  // Base clock enable, marks the prescaler output falling edge.
  output logic                  base_tick_out
);

  typedef struct packed {
    logic [PRE_W-1:0] cnt;
    logic             tick;
  } apwm_pre_s;

  apwm_pre_s st;
  apwm_pre_s next_st;

  // ============================================================
  // divide by n+1
  always_comb begin
    next_st = st;
    if (st.cnt >= preload_in) begin
      next_st.cnt  = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt  = st.cnt + 1'b1;
      next_st.tick = 1'b0;
    end
  end

  // Registered state keeps the enable glitch free.
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign base_tick_out = st.tick;

endmodule

// *** verification/apwm_dac_asserts.sv ***
// ============================================================
// Port checker for apwm_dac.
// Assumes one clock and that every output of the block is registered.
`timescale 1ns/1ns
module apwm_dac_asserts (
  // Clock and reset.
  input wire logic       mclk_in,
  input wire logic       arst_n_in,
  // Control port.
  input wire logic       ctrl_wr_in,
  input wire logic [7:0] ctrl_wdata_in,
  input wire logic [7:0] ctrl_rdata_out,
  // Pads and tick.
  input wire logic       audio_out_a_out,
  input wire logic       audio_out_b_out,
  input wire logic       sample_interrupt_tick_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  int unsigned steady;
  int unsigned gap;
  // ============================================================
  // Helper counters; both saturate so long idle runs stay bounded.
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      steady <= 0;
      gap    <= 0;
    end else begin
      steady <= $changed(ctrl_rdata_out) ? 0 : (steady < 20 ? steady + 1 : steady);
      gap    <= sample_interrupt_tick_out ? 0 : (gap < 999 ? gap + 1 : gap);
    end
  end
  // ============================================================
  // Properties.
  sequence s_off3; ctrl_rdata_out[0] [*3]; endsequence
  property p_wr_load; ctrl_wr_in |=> ctrl_rdata_out == $past(ctrl_wdata_in); endproperty
  property p_hold; !ctrl_wr_in |=> $stable(ctrl_rdata_out); endproperty
  property p_dis_pads; s_off3 |-> !audio_out_a_out && !audio_out_b_out; endproperty
  property p_excl; !(audio_out_a_out && audio_out_b_out); endproperty
  property p_buz; steady >= 14 && ctrl_rdata_out[1:0] == 2'b10 |->
    audio_out_a_out != audio_out_b_out; endproperty
  property p_tick_pulse; sample_interrupt_tick_out |=> !sample_interrupt_tick_out; endproperty
  property p_tick_en; sample_interrupt_tick_out |-> !$past(ctrl_rdata_out[0]); endproperty
  property p_tick_gap; sample_interrupt_tick_out |-> gap >= 63; endproperty
  a_wr_load: assert property (p_wr_load) else $error("control readback wrong");
  a_hold: assert property (p_hold) else $error("control changed unwritten");
  a_dis_pads: assert property (p_dis_pads) else $error("pads driven while off");
  a_excl: assert property (p_excl) else $error("both pads high");
  a_buz: assert property (p_buz) else $error("buzzer pads not opposite");
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick too long");
  a_tick_en: assert property (p_tick_en) else $error("tick while off");
  a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");
endmodule
bind apwm_dac apwm_dac_asserts i_chk (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
  .ctrl_wr_in(ctrl_wr_in), .ctrl_wdata_in(ctrl_wdata_in), .ctrl_rdata_out(ctrl_rdata_out),
  .audio_out_a_out(audio_out_a_out), .audio_out_b_out(audio_out_b_out),
  .sample_interrupt_tick_out(sample_interrupt_tick_out));

// *** verification/apwm_load_model.sv ***
// ============================================================
// Speaker or piezo across the two pads; tallies drive time per pad.
// Assumes pads settle after each rising edge of mclk_in.
`timescale 1ns/1ns
module apwm_load_model (
  // Clock and tally restart.
  input  wire logic mclk_in,
  input  wire logic clr_in,
  // Pads.
  input  wire logic pad_a_in,
  input  wire logic pad_b_in,
  // High-time tallies.
  output int        hi_a_out,
  output int        hi_b_out
);
  // An unknown pad never counts as drive, so it shows up as a short tally.
  always @(posedge mclk_in) begin
    hi_a_out <= clr_in ? 0 : hi_a_out + int'(pad_a_in === 1'b1);
    hi_b_out <= clr_in ? 0 : hi_b_out + int'(pad_b_in === 1'b1);
  end
endmodule

// *** verification/test_audio_pwm_dac_output.sv ***
// ============================================================
// Self-checking bench for apwm_dac with a pad load model.
// Assumes the checker is bound and writes are one-cycle strobes.
`timescale 1ns/1ns
module test_audio_pwm_dac_output;
  logic       mclk_in = 0, arst_n_in = 0, ctrl_wr_in = 0, sample_wr_in = 0, clr = 1;
  logic [7:0] ctrl_wdata_in = 0, sample_wdata_in = 0, ctrl_rdata_out, cfg, smp;
  logic       audio_out_a_out, audio_out_b_out, sample_interrupt_tick_out;
  // Corner settings; the last two reach the 1-in-4 and 1-in-8 interrupt ratios.
  logic [7:0] cc[5] = '{8'h04, 8'h3c, 8'h42, 8'h80, 8'hc6};
  logic [7:0] ss[5] = '{8'h00, 8'h7f, 8'hff, 8'ha2, 8'h40};
  int         err_total = 0, n_checks = 0, cyc = 0, hi_a, hi_b, k, h, per, tol, i;
  apwm_dac i_dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .ctrl_wr_in(ctrl_wr_in),
    .ctrl_wdata_in(ctrl_wdata_in), .ctrl_rdata_out(ctrl_rdata_out),
    .sample_wr_in(sample_wr_in), .sample_wdata_in(sample_wdata_in),
    .audio_out_a_out(audio_out_a_out), .audio_out_b_out(audio_out_b_out),
    .sample_interrupt_tick_out(sample_interrupt_tick_out));
  apwm_load_model i_load (.mclk_in(mclk_in), .clr_in(clr), .pad_a_in(audio_out_a_out),
    .pad_b_in(audio_out_b_out), .hi_a_out(hi_a), .hi_b_out(hi_b));
  // ============================================================
  // Clock and a hang guard well above the longest expected run.
  initial forever #2 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      test_done;
    end
  end
  task automatic test_done;
    if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Compare a register byte exactly.
  task automatic chk8(input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t byte %h exp %h", $time, got, exp);
    end
  endtask
  // Compare a cycle tally within a tolerance, since pad edges land a cycle late.
  task automatic chkn(input int got, exp, t);
    n_checks++;
    if (got < exp - t || got > exp + t) begin
      err_total++;
      $display("MISMATCH %0t count %0d exp %0d", $time, got, exp);
    end
  endtask
  // One-cycle write strobe; sel picks the sample port.
  task automatic wr(input logic sel, input logic [7:0] d);
    @(negedge mclk_in);
    if (sel) {sample_wr_in, sample_wdata_in} = {1'b1, d};
    else {ctrl_wr_in, ctrl_wdata_in} = {1'b1, d};
    @(negedge mclk_in);
    {sample_wr_in, ctrl_wr_in} = 2'b00;
  endtask
  // Count falling edges until a tick is seen, bounded.
  task automatic wait_tick;
    k = 0;
    do begin
      @(negedge mclk_in);
      k++;
    end while (sample_interrupt_tick_out !== 1'b1 && k < 20000);
  endtask
  // Expected high time of the pulsing pad over one tick window.
  function automatic int exp_hi(input logic [7:0] c, s);
    int m = c[2] ? int'(s[6:0]) : int'(s[6:1]);
    return m * (int'(c[5:3]) + 1) * (1 << c[7:6]);
  endfunction
  // ============================================================
  // Main sequence: off state, then corner and random settings.
  initial begin
    void'($urandom(32'h863e9710));
    repeat (6) @(posedge mclk_in);
    @(negedge mclk_in) arst_n_in = 1;
    chk8(ctrl_rdata_out, 8'h01);
    repeat (300) @(negedge mclk_in);
    chk8({5'h00, sample_interrupt_tick_out, audio_out_a_out, audio_out_b_out}, 8'h00);
    // Pass 5 leaves the buffer unwritten, so the previous sample must be reused.
    for (i = 0; i < 11; i++) begin
      cfg = i < 5 ? cc[i] : {1'b0, 7'($urandom)} & 8'hfe;
      wr(0, 8'h01);
      if (i != 5) smp = i < 5 ? ss[i] : 8'($urandom);
      if (i != 5) wr(1, smp);
      wr(0, cfg);
      chk8(ctrl_rdata_out, cfg);
      wait_tick;
      clr = 1;
      @(negedge mclk_in) clr = 0;
      wait_tick;
      per = 64 * (int'(cfg[2]) + 1) * (int'(cfg[5:3]) + 1) * (1 << cfg[7:6]);
      h = exp_hi(cfg, smp);
      tol = (int'(cfg[5:3]) + 1) * (1 << cfg[7:6]) + 2;
      // One falling edge went to the tally clear, so the tick spacing is k plus one.
      chkn(k + 1, per, 0);
      chkn(smp[7] ? hi_b : hi_a, h, tol);
      chkn(smp[7] ? hi_a : hi_b, cfg[1] ? per - h : 0, tol);
    end
    test_done;
  end
endmodule
